//--- src/ldo_ctrl_pkg.sv
// Package with offsets, field layout and reset values for the regulator control registers
package ldo_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 3;
    localparam logic [ADDR_W-1:0] LDO_B_ADDR = 8'h6D;
    localparam logic [ADDR_W-1:0] SD_LDO_ADDR = 8'h6E;
    localparam logic [ADDR_W-1:0] LDO_3V3_ADDR = 8'h6F;
    localparam logic [1:0] IDX_LDO_B = 2'h0;
    localparam logic [1:0] IDX_SD = 2'h1;
    localparam logic [1:0] IDX_3V3 = 2'h2;
    localparam logic [1:0] IDX_NONE = 2'h3;
    localparam int OFF_SEL_BIT = 7;
    localparam int LOWPWR_BIT = 6;
    localparam int STBY_OFF_BIT = 5;
    localparam int ON_BIT = 4;
    localparam int VWIDE_W = 4;
    localparam int VNARROW_W = 2;
    // Writable bit masks; bits 3:2 of the narrow registers are unimplemented
    localparam logic [DATA_W-1:0] WIDE_MASK = 8'hFF;
    localparam logic [DATA_W-1:0] NARROW_MASK = 8'hF3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] OTP_FIELD_MASK = 8'h1F;
endpackage

//--- src/reg_port_if.sv
// Interface carrying the register access between the control block and its storage
`timescale 1ns/1ps
`default_nettype none
interface reg_port_if;
    import ldo_ctrl_pkg::*;
    logic we;
    logic [1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic load;
    logic [DATA_W-1:0] load_data [NUM_REGS];
    logic [DATA_W-1:0] regs [NUM_REGS];
    modport ctrl (output we, idx, wdata, load, load_data, input rdata, regs);
    modport store (input we, idx, wdata, load, load_data, output rdata, regs);
endinterface
`default_nettype wire

//--- src/ldo_reg_store.sv
// Storage for the three regulator control bytes with a registered read port
`timescale 1ns/1ps
`default_nettype none
module ldo_reg_store (
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Access port
    reg_port_if.store port
);
    import ldo_ctrl_pkg::*;

    logic [DATA_W-1:0] mem_q [NUM_REGS];
    logic [DATA_W-1:0] mem_d [NUM_REGS];
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    function automatic logic [DATA_W-1:0] wmask(input logic [1:0] i);
        return (i == IDX_LDO_B) ? WIDE_MASK : NARROW_MASK;
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            mem_d[i] = mem_q[i];
            if (port.load) begin
                // Upper control bits clear; enable and voltage code come from OTP
                mem_d[i] = port.load_data[i] & OTP_FIELD_MASK & wmask(2'(i)); // RULE9 RULE11
            end else if (port.we && port.idx == 2'(i)) begin
                mem_d[i] = port.wdata & wmask(2'(i)); // RULE11
            end
        end
        rdata_d = ZERO_BYTE;
        if (port.idx < 2'(NUM_REGS)) begin
            rdata_d = mem_q[port.idx];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_q[i] <= ZERO_BYTE; // RULE9
            end
            rdata_q <= ZERO_BYTE;
        end else if (ce_i) begin
            mem_q <= mem_d;
            rdata_q <= rdata_d;
        end
    end

    assign port.rdata = rdata_q;
    assign port.regs = mem_q;

    a_narrow_zero: assert property (@(posedge clock_i) disable iff (rst_i) // RULE11
        (mem_q[IDX_SD][3:2] == 2'h0) && (mem_q[IDX_3V3][3:2] == 2'h0))
        else $error("unimplemented bits not zero");
endmodule
`default_nettype wire

//--- src/ldo_regulator_control_regs.sv
// Control registers for the general-purpose, SD-card and 3.3 V linear regulators
// Function
// (RULE1) Bit 7: on power-button turn-off, 0 turns regulator off, 1 gives sleep.
// (RULE2) Bit 6: 1 allows low-power mode, 0 forbids it.
// (RULE3) Bit 5: 1 turns regulator off in standby, 0 keeps it on.
// (RULE4) Bit 4 is the regulator enable.
// (RULE5) General LDO voltage code is bits 3:0 and drives its target voltage.
// (RULE6) SD LDO voltage code is bits 1:0; bits 3:2 unimplemented.
// (RULE7) SD LDO register decodes at 0x6E, read and write anytime; the code drops writes and gives no rvalid_o in the OTP load cycle.
// (RULE8) 3.3 V register decodes at 0x6F with the SD register layout.
// (RULE9) Reset clears bits 7:5; enable and voltage code load from OTP.
// (RULE10) General LDO register decodes at 0x6D.
// (RULE11) Unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module ldo_regulator_control_regs (
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Host register port (functional page)
    input wire logic page_functional_i,
    input wire logic [ldo_ctrl_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ldo_ctrl_pkg::DATA_W-1:0] wdata_i,
    output logic [ldo_ctrl_pkg::DATA_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic hit_o,
    // OTP defaults, loaded one cycle after reset release
    input wire logic [ldo_ctrl_pkg::DATA_W-1:0] otp_ldo_b_i,
    input wire logic [ldo_ctrl_pkg::DATA_W-1:0] otp_sd_ldo_i,
    input wire logic [ldo_ctrl_pkg::DATA_W-1:0] otp_ldo_3v3_i,
    // General-purpose LDO controls
    output logic ldo_b_off_select_o,
    output logic ldo_b_lowpower_allow_o,
    output logic ldo_b_standby_off_o,
    output logic ldo_b_on_o,
    output logic [ldo_ctrl_pkg::VWIDE_W-1:0] ldo_b_vcode_o,
    // SD-card LDO controls
    output logic sd_ldo_off_select_o,
    output logic sd_ldo_lowpower_allow_o,
    output logic sd_ldo_standby_off_o,
    output logic sd_ldo_on_o,
    output logic [ldo_ctrl_pkg::VNARROW_W-1:0] sd_ldo_vcode_o,
    // 3.3 V LDO controls
    output logic ldo_3v3_off_select_o,
    output logic ldo_3v3_lowpower_allow_o,
    output logic ldo_3v3_standby_off_o,
    output logic ldo_3v3_on_o,
    output logic [ldo_ctrl_pkg::VNARROW_W-1:0] ldo_3v3_vcode_o
);
    import ldo_ctrl_pkg::*;

    reg_port_if port ();

    logic load_pend_q;
    logic load_pend_d;
    logic rvalid_q;
    logic rvalid_d;
    logic hit_q;
    logic hit_d;
    logic [1:0] idx;
    logic match;

    function automatic logic decode(input logic [ADDR_W-1:0] a, output logic [1:0] i);
        i = IDX_LDO_B;
        decode = 1'b1;
        unique case (a)
            LDO_B_ADDR: i = IDX_LDO_B; // RULE10
            SD_LDO_ADDR: i = IDX_SD; // RULE7
            LDO_3V3_ADDR: i = IDX_3V3; // RULE8
            default: decode = 1'b0;
        endcase
    endfunction

    always_comb begin
        match = decode(addr_i, idx) && page_functional_i;
        load_pend_d = 1'b0;
        rvalid_d = rd_i && !load_pend_q;
        hit_d = (rd_i || wr_i) && match;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            load_pend_q <= 1'b1; // RULE9
            rvalid_q <= 1'b0;
            hit_q <= 1'b0;
        end else if (ce_i) begin
            load_pend_q <= load_pend_d;
            rvalid_q <= rvalid_d;
            hit_q <= hit_d;
        end
    end

    assign port.load = load_pend_q;
    assign port.load_data[IDX_LDO_B] = otp_ldo_b_i;
    assign port.load_data[IDX_SD] = otp_sd_ldo_i;
    assign port.load_data[IDX_3V3] = otp_ldo_3v3_i;
    assign port.we = wr_i && match && !load_pend_q; // RULE7 RULE8 RULE10
    assign port.idx = match ? idx : IDX_NONE;
    assign port.wdata = wdata_i;

    ldo_reg_store u_store (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .port(port)
    );

    assign rdata_o = port.rdata;
    assign rvalid_o = rvalid_q;
    assign hit_o = hit_q;

    assign ldo_b_off_select_o = port.regs[IDX_LDO_B][OFF_SEL_BIT]; // RULE1
    assign ldo_b_lowpower_allow_o = port.regs[IDX_LDO_B][LOWPWR_BIT]; // RULE2
    assign ldo_b_standby_off_o = port.regs[IDX_LDO_B][STBY_OFF_BIT]; // RULE3
    assign ldo_b_on_o = port.regs[IDX_LDO_B][ON_BIT]; // RULE4
    assign ldo_b_vcode_o = port.regs[IDX_LDO_B][VWIDE_W-1:0]; // RULE5
    assign sd_ldo_off_select_o = port.regs[IDX_SD][OFF_SEL_BIT]; // RULE1
    assign sd_ldo_lowpower_allow_o = port.regs[IDX_SD][LOWPWR_BIT]; // RULE2
    assign sd_ldo_standby_off_o = port.regs[IDX_SD][STBY_OFF_BIT]; // RULE3
    assign sd_ldo_on_o = port.regs[IDX_SD][ON_BIT]; // RULE4
    assign sd_ldo_vcode_o = port.regs[IDX_SD][VNARROW_W-1:0]; // RULE6
    assign ldo_3v3_off_select_o = port.regs[IDX_3V3][OFF_SEL_BIT]; // RULE1
    assign ldo_3v3_lowpower_allow_o = port.regs[IDX_3V3][LOWPWR_BIT]; // RULE2
    assign ldo_3v3_standby_off_o = port.regs[IDX_3V3][STBY_OFF_BIT]; // RULE3
    assign ldo_3v3_on_o = port.regs[IDX_3V3][ON_BIT]; // RULE4
    assign ldo_3v3_vcode_o = port.regs[IDX_3V3][VNARROW_W-1:0]; // RULE8

    // Accepted writes, one per regulator register
    sequence s_write_sd;
        wr_i && page_functional_i && addr_i == SD_LDO_ADDR && !load_pend_q && ce_i;
    endsequence

    sequence s_write_3v3;
        wr_i && page_functional_i && addr_i == LDO_3V3_ADDR && !load_pend_q && ce_i;
    endsequence

    sequence s_write_ldob;
        wr_i && page_functional_i && addr_i == LDO_B_ADDR && !load_pend_q && ce_i;
    endsequence

    // Read taken on this edge, answered on the next
    sequence s_read_taken;
        rd_i && !load_pend_q && ce_i;
    endsequence

    // Edge that copies the OTP defaults in after reset release
    sequence s_otp_load;
        load_pend_q && ce_i && !rst_i;
    endsequence

    // SD-card regulator write path
    a_sd_write_lands: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        s_write_sd |=> (sd_ldo_on_o == $past(wdata_i[ON_BIT]))
            && (sd_ldo_vcode_o == $past(wdata_i[VNARROW_W-1:0])))
        else $error("sd register write lost");
    a_sd_off_select: assert property (@(posedge clock_i) disable iff (rst_i) // RULE1
        s_write_sd |=> sd_ldo_off_select_o == $past(wdata_i[OFF_SEL_BIT]))
        else $error("sd off select not written");
    a_sd_lowpower: assert property (@(posedge clock_i) disable iff (rst_i) // RULE2
        s_write_sd |=> sd_ldo_lowpower_allow_o == $past(wdata_i[LOWPWR_BIT]))
        else $error("sd low-power allow not written");
    a_sd_standby: assert property (@(posedge clock_i) disable iff (rst_i) // RULE3
        s_write_sd |=> sd_ldo_standby_off_o == $past(wdata_i[STBY_OFF_BIT]))
        else $error("sd standby off not written");

    // 3.3 V regulator write path
    a_3v3_write_lands: assert property (@(posedge clock_i) disable iff (rst_i) // RULE8
        s_write_3v3 |=> ldo_3v3_off_select_o == $past(wdata_i[OFF_SEL_BIT]))
        else $error("3v3 register write lost");
    a_3v3_lowpower: assert property (@(posedge clock_i) disable iff (rst_i) // RULE2
        s_write_3v3 |=> ldo_3v3_lowpower_allow_o == $past(wdata_i[LOWPWR_BIT]))
        else $error("3v3 low-power allow not written");
    a_3v3_standby: assert property (@(posedge clock_i) disable iff (rst_i) // RULE3
        s_write_3v3 |=> ldo_3v3_standby_off_o == $past(wdata_i[STBY_OFF_BIT]))
        else $error("3v3 standby off not written");
    a_3v3_enable: assert property (@(posedge clock_i) disable iff (rst_i) // RULE4
        s_write_3v3 |=> ldo_3v3_on_o == $past(wdata_i[ON_BIT]))
        else $error("3v3 enable not written");
    a_3v3_vcode: assert property (@(posedge clock_i) disable iff (rst_i) // RULE8
        s_write_3v3 |=> ldo_3v3_vcode_o == $past(wdata_i[VNARROW_W-1:0]))
        else $error("3v3 voltage code not written");

    // General-purpose regulator write path
    a_ldob_write_lands: assert property (@(posedge clock_i) disable iff (rst_i) // RULE5 RULE10
        s_write_ldob |=> ldo_b_vcode_o == $past(wdata_i[VWIDE_W-1:0]))
        else $error("general ldo write lost");
    a_ldob_off_select: assert property (@(posedge clock_i) disable iff (rst_i) // RULE1
        s_write_ldob |=> ldo_b_off_select_o == $past(wdata_i[OFF_SEL_BIT]))
        else $error("general ldo off select not written");
    a_ldob_lowpower: assert property (@(posedge clock_i) disable iff (rst_i) // RULE2
        s_write_ldob |=> ldo_b_lowpower_allow_o == $past(wdata_i[LOWPWR_BIT]))
        else $error("general ldo low-power allow not written");
    a_ldob_standby: assert property (@(posedge clock_i) disable iff (rst_i) // RULE3
        s_write_ldob |=> ldo_b_standby_off_o == $past(wdata_i[STBY_OFF_BIT]))
        else $error("general ldo standby off not written");
    a_ldob_enable: assert property (@(posedge clock_i) disable iff (rst_i) // RULE4
        s_write_ldob |=> ldo_b_on_o == $past(wdata_i[ON_BIT]))
        else $error("general ldo enable not written");

    // Registers that are not addressed keep their contents
    a_sd_hold: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        !load_pend_q && !(wr_i && page_functional_i && addr_i == SD_LDO_ADDR)
        |=> $stable(sd_ldo_off_select_o) && $stable(sd_ldo_lowpower_allow_o)
            && $stable(sd_ldo_standby_off_o) && $stable(sd_ldo_on_o) && $stable(sd_ldo_vcode_o))
        else $error("sd register changed without a write");
    a_3v3_hold: assert property (@(posedge clock_i) disable iff (rst_i) // RULE8
        !load_pend_q && !(wr_i && page_functional_i && addr_i == LDO_3V3_ADDR)
        |=> $stable(ldo_3v3_off_select_o) && $stable(ldo_3v3_lowpower_allow_o)
            && $stable(ldo_3v3_standby_off_o) && $stable(ldo_3v3_on_o) && $stable(ldo_3v3_vcode_o))
        else $error("3v3 register changed without a write");
    a_ldob_hold: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
        !load_pend_q && !(wr_i && page_functional_i && addr_i == LDO_B_ADDR)
        |=> $stable(ldo_b_off_select_o) && $stable(ldo_b_lowpower_allow_o)
            && $stable(ldo_b_standby_off_o) && $stable(ldo_b_on_o) && $stable(ldo_b_vcode_o))
        else $error("general ldo register changed without a write");
    a_other_page_ignored: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
        (wr_i && !page_functional_i && !load_pend_q) |=> $stable(ldo_b_vcode_o))
        else $error("write outside functional page");

    // Reset and the OTP load that follows it
    a_reset_zero: assert property (@(posedge clock_i) // RULE9
        rst_i |=> !ldo_b_on_o && !sd_ldo_on_o && !ldo_3v3_on_o && !(|ldo_b_vcode_o)
            && !(|sd_ldo_vcode_o) && !(|ldo_3v3_vcode_o) && rdata_o == ZERO_BYTE && !rvalid_o && !hit_o)
        else $error("state not cleared by reset");
    a_reset_clears: assert property (@(posedge clock_i) disable iff (rst_i) // RULE9
        s_otp_load |=> !ldo_b_off_select_o && !ldo_b_lowpower_allow_o && !ldo_b_standby_off_o
            && !sd_ldo_off_select_o && !sd_ldo_lowpower_allow_o && !sd_ldo_standby_off_o
            && !ldo_3v3_off_select_o && !ldo_3v3_lowpower_allow_o && !ldo_3v3_standby_off_o)
        else $error("upper control bits not cleared");
    a_otp_enable: assert property (@(posedge clock_i) disable iff (rst_i) // RULE9
        s_otp_load |=> sd_ldo_on_o == $past(otp_sd_ldo_i[ON_BIT]))
        else $error("enable not loaded from otp");
    a_otp_enables: assert property (@(posedge clock_i) disable iff (rst_i) // RULE9
        s_otp_load |=> ldo_b_on_o == $past(otp_ldo_b_i[ON_BIT])
            && ldo_3v3_on_o == $past(otp_ldo_3v3_i[ON_BIT]))
        else $error("enables not loaded from otp");
    a_otp_vcode: assert property (@(posedge clock_i) disable iff (rst_i) // RULE9
        s_otp_load |=> ldo_b_vcode_o == $past(otp_ldo_b_i[VWIDE_W-1:0])
            && sd_ldo_vcode_o == $past(otp_sd_ldo_i[VNARROW_W-1:0])
            && ldo_3v3_vcode_o == $past(otp_ldo_3v3_i[VNARROW_W-1:0]))
        else $error("voltage codes not loaded from otp");
    a_load_once: assert property (@(posedge clock_i) disable iff (rst_i) // RULE9
        s_otp_load |=> !load_pend_q)
        else $error("otp load repeated");
    a_load_blocks: assert property (@(posedge clock_i) disable iff (rst_i) // RULE9
        s_otp_load |=> !rvalid_o)
        else $error("read answered during otp load");

    // Read data, read valid and address hit
    a_read_returns: assert property (@(posedge clock_i) disable iff (rst_i) // RULE11
        (rd_i && page_functional_i && addr_i == SD_LDO_ADDR && !load_pend_q && !wr_i && ce_i)
        |=> rdata_o[ON_BIT] == sd_ldo_on_o && rdata_o[3:2] == 2'h0)
        else $error("sd readback wrong");
    a_read_sd_full: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        (rd_i && page_functional_i && addr_i == SD_LDO_ADDR && !load_pend_q && !wr_i && ce_i)
        |=> rdata_o == {sd_ldo_off_select_o, sd_ldo_lowpower_allow_o, sd_ldo_standby_off_o,
            sd_ldo_on_o, 2'h0, sd_ldo_vcode_o})
        else $error("sd full readback wrong");
    a_read_ldob: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
        (rd_i && page_functional_i && addr_i == LDO_B_ADDR && !load_pend_q && !wr_i && ce_i)
        |=> rdata_o == {ldo_b_off_select_o, ldo_b_lowpower_allow_o, ldo_b_standby_off_o,
            ldo_b_on_o, ldo_b_vcode_o})
        else $error("general ldo readback wrong");
    a_read_3v3: assert property (@(posedge clock_i) disable iff (rst_i) // RULE8
        (rd_i && page_functional_i && addr_i == LDO_3V3_ADDR && !load_pend_q && !wr_i && ce_i)
        |=> rdata_o == {ldo_3v3_off_select_o, ldo_3v3_lowpower_allow_o, ldo_3v3_standby_off_o,
            ldo_3v3_on_o, 2'h0, ldo_3v3_vcode_o})
        else $error("3v3 readback wrong");
    a_unmapped_zero: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
        ce_i && (!page_functional_i
            || (addr_i != LDO_B_ADDR && addr_i != SD_LDO_ADDR && addr_i != LDO_3V3_ADDR))
        |=> rdata_o == ZERO_BYTE)
        else $error("unmapped read not zero");
    a_rvalid_pulse: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        s_read_taken |=> rvalid_o)
        else $error("read not answered");
    a_rvalid_idle: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        ce_i && !rd_i |=> !rvalid_o)
        else $error("read valid without a read");
    a_hit_mapped: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        ce_i && (rd_i || wr_i) && page_functional_i
            && (addr_i == LDO_B_ADDR || addr_i == SD_LDO_ADDR || addr_i == LDO_3V3_ADDR) |=> hit_o)
        else $error("mapped access not flagged");
    a_hit_refused: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
        ce_i && (!page_functional_i
            || (addr_i != LDO_B_ADDR && addr_i != SD_LDO_ADDR && addr_i != LDO_3V3_ADDR)) |=> !hit_o)
        else $error("refused access flagged as hit");

    // Clock enable low freezes every register
    a_freeze: assert property (@(posedge clock_i) disable iff (rst_i) // RULE4
        !ce_i |=> $stable(ldo_b_on_o) && $stable(rdata_o))
        else $error("state moved with enable low");
    a_freeze_status: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
        !ce_i |=> $stable(sd_ldo_vcode_o) && $stable(ldo_3v3_on_o)
            && $stable(hit_o) && $stable(rvalid_o))
        else $error("status moved with enable low");
    a_freeze_ldob: assert property (@(posedge clock_i) disable iff (rst_i) // RULE5
        !ce_i |=> $stable(ldo_b_vcode_o) && $stable(sd_ldo_off_select_o)
            && $stable(ldo_3v3_vcode_o))
        else $error("voltage codes moved with enable low");
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking testbench for the regulator control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb;
    import ldo_ctrl_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic page_functional_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] otp_b = 8'h00;
    logic [7:0] otp_sd = 8'h00;
    logic [7:0] otp_33 = 8'h00;
    logic [7:0] rdata_o;
    logic rvalid_o, hit_o;
    logic b_os, b_lp, b_sb, b_on, s_os, s_lp, s_sb, s_on, t_os, t_lp, t_sb, t_on;
    logic [3:0] b_v;
    logic [1:0] s_v, t_v;
    logic [7:0] adr [3] = '{LDO_B_ADDR, SD_LDO_ADDR, LDO_3V3_ADDR};
    logic [7:0] msk [3] = '{WIDE_MASK, NARROW_MASK, NARROW_MASK};
    logic [7:0] exp_q [3];
    logic [7:0] pat [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    int fail_count = 0;
    int n_compared = 0;
    always #2 clock_i = ~clock_i;
    ldo_regulator_control_regs i_ldo_regulator_control_regs (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
        .page_functional_i(page_functional_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .hit_o(hit_o), .otp_ldo_b_i(otp_b), .otp_sd_ldo_i(otp_sd),
        .otp_ldo_3v3_i(otp_33), .ldo_b_off_select_o(b_os), .ldo_b_lowpower_allow_o(b_lp),
        .ldo_b_standby_off_o(b_sb), .ldo_b_on_o(b_on), .ldo_b_vcode_o(b_v), .sd_ldo_off_select_o(s_os),
        .sd_ldo_lowpower_allow_o(s_lp), .sd_ldo_standby_off_o(s_sb), .sd_ldo_on_o(s_on), .sd_ldo_vcode_o(s_v),
        .ldo_3v3_off_select_o(t_os), .ldo_3v3_lowpower_allow_o(t_lp), .ldo_3v3_standby_off_o(t_sb),
        .ldo_3v3_on_o(t_on), .ldo_3v3_vcode_o(t_v));
    // Regulator outputs packed back into register layout
    function automatic logic [7:0] outs(input int r);
        if (r == 0) return {b_os, b_lp, b_sb, b_on, b_v};
        if (r == 1) return {s_os, s_lp, s_sb, s_on, 2'b00, s_v};
        return {t_os, t_lp, t_sb, t_on, 2'b00, t_v};
    endfunction
    task automatic check_all();
        for (int r = 0; r < 3; r++) `CHK(outs(r), exp_q[r])
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pg, input logic h);
        @(negedge clock_i);
        addr_i = a; wdata_i = d; page_functional_i = pg; wr_i = 1'b1;
        @(negedge clock_i);
        wr_i = 1'b0;
        `CHK(hit_o, h)
        `CHK(rvalid_o, 1'b0)
    endtask
    task automatic rd(input logic [7:0] a, input logic pg, input logic [7:0] d, input logic h);
        @(negedge clock_i);
        addr_i = a; page_functional_i = pg; rd_i = 1'b1;
        @(negedge clock_i);
        rd_i = 1'b0;
        `CHK(rvalid_o, 1'b1)
        `CHK(rdata_o, d)
        `CHK(hit_o, h)
    endtask
    task automatic t_reset(input logic [7:0] ob, input logic [7:0] os, input logic [7:0] o3);
        @(negedge clock_i);
        rst_i = 1'b1; otp_b = ob; otp_sd = os; otp_33 = o3;
        repeat (12) @(negedge clock_i);
        exp_q = '{8'h00, 8'h00, 8'h00};
        check_all();
        rst_i = 1'b0;
        @(negedge clock_i);
        exp_q = '{ob & 8'h1F, os & 8'h13, o3 & 8'h13};
        check_all();
    endtask
    task automatic t_write_read();
        for (int r = 0; r < 3; r++) begin
            for (int p = 0; p < 4; p++) begin
                wr(adr[r], pat[p], 1'b1, 1'b1);
                exp_q[r] = pat[p] & msk[r];
                check_all();
                rd(adr[r], 1'b1, exp_q[r], 1'b1);
            end
        end
    endtask
    task automatic t_refused();
        wr(8'h6C, 8'hFF, 1'b1, 1'b0);
        wr(8'h70, 8'hFF, 1'b1, 1'b0);
        wr(SD_LDO_ADDR, 8'hFF, 1'b0, 1'b0);
        check_all();
        rd(8'h6C, 1'b1, 8'h00, 1'b0);
        rd(LDO_3V3_ADDR, 1'b0, 8'h00, 1'b0);
    endtask
    task automatic t_overlap();
        @(negedge clock_i);
        addr_i = SD_LDO_ADDR; wdata_i = 8'hD2; page_functional_i = 1'b1; wr_i = 1'b1; rd_i = 1'b1;
        @(negedge clock_i);
        wr_i = 1'b0; rd_i = 1'b0;
        `CHK(rdata_o, exp_q[1])
        exp_q[1] = 8'hD2;
        check_all();
        @(negedge clock_i);
        ce_i = 1'b0; addr_i = LDO_B_ADDR; wdata_i = 8'h3C; wr_i = 1'b1;
        @(negedge clock_i);
        wr_i = 1'b0; ce_i = 1'b1;
        check_all();
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #12000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        t_reset(8'hFF, 8'hFF, 8'hEE);
        t_write_read();
        t_refused();
        t_overlap();
        t_reset(8'hE5, 8'h2C, 8'h11);
        rd(LDO_3V3_ADDR, 1'b1, 8'h11, 1'b1);
        report_and_stop();
    end
endmodule
`undef CHK
`default_nettype wire
